// File: rtc_cal_pkg.sv
// Purpose: Shared constants and types for the calendar and calibration output block.
// Assumes: 10 MHz system clock; 8-bit registers at fixed offsets.
// Notes: Counts above 4096 cycles are overridable parameters of the top module.
// Function
// (RULE1) In deepest sleep, output only on port0_pin5, needing sleep route and enable.
// (RULE2) Enable clear drives nothing; enable set when awake drives every pin with routing bit set.
// (RULE3) Enable and routing bit 3 drive the output on port2_pin3.
// (RULE4) Enable and routing bit 2 drive the output on port1_pin2.
// (RULE5) Enable and routing bit 1 drive the output on port0_pin7.
// (RULE6) Enable and routing bit 0 drive the output on port0_pin5 when awake.
// (RULE7) Date wraps after 31, 30 or 28/29 days depending on month code.
// (RULE8) Year codes 4 to 96 divisible by four are leap; February gets 29 days.
// (RULE9) Select 00 gives 1 Hz, 01 gives 512 Hz, long accuracy window.
// (RULE10) Select 10 gives 500 Hz, 11 gives 16 kHz, short window.
// (RULE11) Fast selects make timekeeping run 125 times faster.
// (RULE12) On date wrap, date reloads to 01 and month increments.
// (RULE13) Month codes outside 1 to 12 use the 31-day rollover.
`default_nettype none
package rtc_cal_pkg;
    // Clock and output rates
    localparam int CLK_HZ = 10_000_000;
    localparam int FREQ_1HZ = 1;
    localparam int FREQ_512HZ = 512;
    localparam int FREQ_500HZ = 500;
    localparam int FREQ_16KHZ = 16_000;
    localparam int TICK_HZ = 128;
    localparam int FAST_FACTOR = 125;
    localparam int DIV_W = 24;
    // Half periods and timebase in clock cycles
    localparam int HALF_1HZ = CLK_HZ / (2 * FREQ_1HZ);
    localparam int HALF_512HZ = CLK_HZ / (2 * FREQ_512HZ);
    localparam int HALF_500HZ = CLK_HZ / (2 * FREQ_500HZ);
    localparam int HALF_16KHZ = CLK_HZ / (2 * FREQ_16KHZ);
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    // Register offsets
    localparam logic [3:0] OFF_FRAC = 4'h1;
    localparam logic [3:0] OFF_SEC = 4'h2;
    localparam logic [3:0] OFF_MIN = 4'h3;
    localparam logic [3:0] OFF_HOUR = 4'h4;
    localparam logic [3:0] OFF_DAY = 4'h5;
    localparam logic [3:0] OFF_DATE = 4'h6;
    localparam logic [3:0] OFF_MONTH = 4'h7;
    localparam logic [3:0] OFF_YEAR = 4'h8;
    localparam logic [3:0] OFF_CAL = 4'hF;
    // Counter limits
    localparam logic [7:0] FRAC_MAX = 8'h7F;
    localparam logic [7:0] SEC_MAX = 8'h3B;
    localparam logic [7:0] HOUR_MAX = 8'h17;
    localparam logic [7:0] DAY_MAX = 8'h06;
    localparam logic [7:0] MONTH_MAX = 8'h0C;
    localparam logic [7:0] YEAR_MAX = 8'h63;
    localparam logic [7:0] LEAP_LAST = 8'h60;
    localparam logic [7:0] MONTH_FEB = 8'h02;
    localparam logic [7:0] MONTH_APR = 8'h04;
    localparam logic [7:0] MONTH_JUN = 8'h06;
    localparam logic [7:0] MONTH_SEP = 8'h09;
    localparam logic [7:0] MONTH_NOV = 8'h0B;
    localparam logic [7:0] DAYS_LONG = 8'h1F;
    localparam logic [7:0] DAYS_SHORT = 8'h1E;
    localparam logic [7:0] DAYS_FEB = 8'h1C;
    localparam logic [7:0] DAYS_FEB_LEAP = 8'h1D;
    // Values after reset
    localparam logic [7:0] ZERO_RST = 8'h00;
    localparam logic [7:0] DATE_RST = 8'h01;
    localparam logic [7:0] MONTH_RST = 8'h01;
    localparam logic [7:0] CAL_RST = 8'h00;
    // Frequency select codes
    typedef enum logic [1:0] {
        CAL_FREQ_SELECT_1HZ = 2'b00,
        CAL_FREQ_SELECT_512HZ = 2'b01,
        CAL_FREQ_SELECT_500HZ = 2'b10,
        CAL_FREQ_SELECT_16KHZ = 2'b11
    } cal_freq_t;
    // One bit per output pin, in routing bit order
    typedef struct packed {
        logic route_port2_pin3;
        logic route_port1_pin2;
        logic route_port0_pin7;
        logic route_port0_pin5;
    } cal_pins_t;
    // Calibration output configuration layout
    typedef struct packed {
        logic sleep_output_route;
        logic output_enable;
        cal_freq_t cal_freq_select;
        cal_pins_t route;
    } cal_cfg_t;
endpackage
`default_nettype wire

// File: cal_wave.sv
// Purpose: Square wave generator for the calibration output.
// Assumes: Selection may change at any time; the wave restarts on a change.
// Notes: Half periods are parameters so a bench can shorten them.
`default_nettype none
module cal_wave #(
    parameter logic [rtc_cal_pkg::DIV_W-1:0] HALF_1HZ_P = rtc_cal_pkg::DIV_W'(rtc_cal_pkg::HALF_1HZ),
    parameter logic [rtc_cal_pkg::DIV_W-1:0] HALF_512HZ_P = rtc_cal_pkg::DIV_W'(rtc_cal_pkg::HALF_512HZ),
    parameter logic [rtc_cal_pkg::DIV_W-1:0] HALF_500HZ_P = rtc_cal_pkg::DIV_W'(rtc_cal_pkg::HALF_500HZ),
    parameter logic [rtc_cal_pkg::DIV_W-1:0] HALF_16KHZ_P = rtc_cal_pkg::DIV_W'(rtc_cal_pkg::HALF_16KHZ)
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Rate selection
    input wire rtc_cal_pkg::cal_freq_t freq_select,
    // Wave
    output logic wave_out
);
    import rtc_cal_pkg::*;

    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_next;
    logic wave_reg;
    logic wave_next;
    cal_freq_t sel_reg;
    cal_freq_t sel_next;
    logic [DIV_W-1:0] half;

    // Half period for the selected rate
    always_comb
    begin
        case (freq_select)
            CAL_FREQ_SELECT_1HZ: half = HALF_1HZ_P; // RULE9
            CAL_FREQ_SELECT_512HZ: half = HALF_512HZ_P; // RULE9
            CAL_FREQ_SELECT_500HZ: half = HALF_500HZ_P; // RULE10
            CAL_FREQ_SELECT_16KHZ: half = HALF_16KHZ_P; // RULE10
            default: half = HALF_1HZ_P;
        endcase
    end

    // Divider and toggle
    always_comb
    begin
        div_next = div_reg + DIV_W'(1);
        wave_next = wave_reg;
        sel_next = freq_select;
        if (freq_select != sel_reg)
        begin
            div_next = '0;
            wave_next = 1'b0;
        end
        else if (div_reg >= half - DIV_W'(1))
        begin
            div_next = '0;
            wave_next = ~wave_reg;
        end
    end

    // State registers
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            div_reg <= '0;
            wave_reg <= 1'b0;
            sel_reg <= CAL_FREQ_SELECT_1HZ;
        end
        else
        begin
            div_reg <= div_next;
            wave_reg <= wave_next;
            sel_reg <= sel_next;
        end
    end

    assign wave_out = wave_reg;
endmodule
`default_nettype wire

// File: rtc_calendar_cal.sv
// Purpose: Calendar counters and routed calibration pulse output.
// Assumes: Single system clock; register port with read data one cycle later.
// Notes: A software write beats a count in the same cycle.
`default_nettype none
module rtc_calendar_cal #(
    parameter logic [rtc_cal_pkg::DIV_W-1:0] TICK_CYCLES_P = rtc_cal_pkg::DIV_W'(rtc_cal_pkg::TICK_CYCLES),
    parameter logic [rtc_cal_pkg::DIV_W-1:0] HALF_1HZ_P = rtc_cal_pkg::DIV_W'(rtc_cal_pkg::HALF_1HZ),
    parameter logic [rtc_cal_pkg::DIV_W-1:0] HALF_512HZ_P = rtc_cal_pkg::DIV_W'(rtc_cal_pkg::HALF_512HZ),
    parameter logic [rtc_cal_pkg::DIV_W-1:0] HALF_500HZ_P = rtc_cal_pkg::DIV_W'(rtc_cal_pkg::HALF_500HZ)
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Power mode
    input wire logic deepest_sleep_mode,
    // Calibration pins
    output rtc_cal_pkg::cal_pins_t cal_pin_level,
    output rtc_cal_pkg::cal_pins_t cal_pin_drive
);
    import rtc_cal_pkg::*;

    localparam logic [DIV_W-1:0] FAST_TICK = DIV_W'(TICK_CYCLES_P / DIV_W'(FAST_FACTOR));

    cal_cfg_t cfg_reg;
    cal_cfg_t cfg_next;
    logic [DIV_W-1:0] tick_reg;
    logic [DIV_W-1:0] tick_next;
    logic [7:0] frac_reg;
    logic [7:0] frac_next;
    logic [7:0] sec_reg;
    logic [7:0] sec_next;
    logic [7:0] min_reg;
    logic [7:0] min_next;
    logic [7:0] hour_reg;
    logic [7:0] hour_next;
    logic [7:0] day_reg;
    logic [7:0] day_next;
    logic [7:0] date_reg;
    logic [7:0] date_next;
    logic [7:0] month_reg;
    logic [7:0] month_next;
    logic [7:0] year_reg;
    logic [7:0] year_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    cal_pins_t level_reg;
    cal_pins_t level_next;
    cal_pins_t drive_reg;
    cal_pins_t drive_next;
    logic [DIV_W-1:0] tick_limit;
    logic tick_hit;
    logic fast_mode;
    logic wave;

    // Last date of a month, 31 days for unknown codes
    function automatic logic [7:0] last_date(input logic [7:0] month, input logic [7:0] year);
        logic leap;
        leap = (year[1:0] == 2'b00) && (year != ZERO_RST) && (year <= LEAP_LAST); // RULE8
        case (month)
            MONTH_FEB: last_date = leap ? DAYS_FEB_LEAP : DAYS_FEB; // RULE8
            MONTH_APR, MONTH_JUN, MONTH_SEP, MONTH_NOV: last_date = DAYS_SHORT; // RULE7
            default: last_date = DAYS_LONG; // RULE13
        endcase
    endfunction

    cal_wave #(
        .HALF_1HZ_P(HALF_1HZ_P),
        .HALF_512HZ_P(HALF_512HZ_P),
        .HALF_500HZ_P(HALF_500HZ_P)
    ) u_wave (
        .clk_sys(clk_sys),
        .reset(reset),
        .freq_select(cfg_reg.cal_freq_select),
        .wave_out(wave)
    );

    // Timebase: fast selections shorten the tick
    assign fast_mode = cfg_reg.cal_freq_select[1]; // RULE11
    assign tick_limit = fast_mode ? FAST_TICK : TICK_CYCLES_P; // RULE11
    assign tick_hit = tick_reg >= tick_limit - DIV_W'(1);

    // Calendar counting and register writes
    always_comb
    begin
        tick_next = tick_hit ? '0 : tick_reg + DIV_W'(1);
        frac_next = frac_reg;
        sec_next = sec_reg;
        min_next = min_reg;
        hour_next = hour_reg;
        day_next = day_reg;
        date_next = date_reg;
        month_next = month_reg;
        year_next = year_reg;
        cfg_next = cfg_reg;
        if (tick_hit)
        begin
            frac_next = frac_reg + 8'h01;
            if (frac_reg >= FRAC_MAX)
            begin
                frac_next = ZERO_RST;
                sec_next = sec_reg + 8'h01;
                if (sec_reg >= SEC_MAX)
                begin
                    sec_next = ZERO_RST;
                    min_next = min_reg + 8'h01;
                    if (min_reg >= SEC_MAX)
                    begin
                        min_next = ZERO_RST;
                        hour_next = hour_reg + 8'h01;
                        if (hour_reg >= HOUR_MAX)
                        begin
                            hour_next = ZERO_RST;
                            day_next = (day_reg >= DAY_MAX) ? ZERO_RST : day_reg + 8'h01;
                            date_next = date_reg + 8'h01;
                            if (date_reg >= last_date(month_reg, year_reg)) // RULE7
                            begin
                                date_next = DATE_RST; // RULE12
                                month_next = month_reg + 8'h01; // RULE12
                                if (month_reg >= MONTH_MAX)
                                begin
                                    month_next = MONTH_RST;
                                    year_next = (year_reg >= YEAR_MAX) ? ZERO_RST : year_reg + 8'h01;
                                end
                            end
                        end
                    end
                end
            end
        end
        if (reg_write)
        begin
            case (reg_addr)
                OFF_FRAC: frac_next = reg_wdata;
                OFF_SEC: sec_next = reg_wdata;
                OFF_MIN: min_next = reg_wdata;
                OFF_HOUR: hour_next = reg_wdata;
                OFF_DAY: day_next = reg_wdata;
                OFF_DATE: date_next = reg_wdata;
                OFF_MONTH: month_next = reg_wdata;
                OFF_YEAR: year_next = reg_wdata;
                OFF_CAL: cfg_next = cal_cfg_t'(reg_wdata);
                default: cfg_next = cfg_reg;
            endcase
        end
    end

    // Read data for the cycle after the strobe
    always_comb
    begin
        rdata_next = ZERO_RST;
        if (reg_read)
        begin
            case (reg_addr)
                OFF_FRAC: rdata_next = frac_reg;
                OFF_SEC: rdata_next = sec_reg;
                OFF_MIN: rdata_next = min_reg;
                OFF_HOUR: rdata_next = hour_reg;
                OFF_DAY: rdata_next = day_reg;
                OFF_DATE: rdata_next = date_reg;
                OFF_MONTH: rdata_next = month_reg;
                OFF_YEAR: rdata_next = year_reg;
                OFF_CAL: rdata_next = cfg_reg;
                default: rdata_next = ZERO_RST;
            endcase
        end
    end

    // Pin routing
    always_comb
    begin
        drive_next = '0; // RULE2
        if (cfg_reg.output_enable)
        begin
            if (deepest_sleep_mode)
            begin
                drive_next.route_port0_pin5 = cfg_reg.sleep_output_route; // RULE1
            end
            else
            begin
                drive_next.route_port2_pin3 = cfg_reg.route.route_port2_pin3; // RULE3
                drive_next.route_port1_pin2 = cfg_reg.route.route_port1_pin2; // RULE4
                drive_next.route_port0_pin7 = cfg_reg.route.route_port0_pin7; // RULE5
                drive_next.route_port0_pin5 = cfg_reg.route.route_port0_pin5; // RULE6
            end
        end
        level_next = drive_next & {4{wave}}; // RULE2
    end

    // State registers
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            tick_reg <= '0;
            frac_reg <= ZERO_RST;
            sec_reg <= ZERO_RST;
            min_reg <= ZERO_RST;
            hour_reg <= ZERO_RST;
            day_reg <= ZERO_RST;
            date_reg <= DATE_RST;
            month_reg <= MONTH_RST;
            year_reg <= ZERO_RST;
            cfg_reg <= cal_cfg_t'(CAL_RST);
            rdata_reg <= ZERO_RST;
            level_reg <= '0;
            drive_reg <= '0;
        end
        else
        begin
            tick_reg <= tick_next;
            frac_reg <= frac_next;
            sec_reg <= sec_next;
            min_reg <= min_next;
            hour_reg <= hour_next;
            day_reg <= day_next;
            date_reg <= date_next;
            month_reg <= month_next;
            year_reg <= year_next;
            cfg_reg <= cfg_next;
            rdata_reg <= rdata_next;
            level_reg <= level_next;
            drive_reg <= drive_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign cal_pin_level = level_reg;
    assign cal_pin_drive = drive_reg;
endmodule
`default_nettype wire

// File: rtc_calendar_cal_chk.sv
// Purpose: Port assertions for the calendar and calibration block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the top module.
`default_nettype none
module rtc_calendar_cal_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // Pins
    input wire logic deepest_sleep_mode,
    input wire rtc_cal_pkg::cal_pins_t cal_pin_level,
    input wire rtc_cal_pkg::cal_pins_t cal_pin_drive
);
    import rtc_cal_pkg::*;
    logic cfg_wr;
    // Config write seen at the port
    assign cfg_wr = reg_write && reg_addr == OFF_CAL;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Pin drive against written config
    route_awake_a: assert property (cfg_wr ##1 (!cfg_wr && !deepest_sleep_mode) |=>
        cal_pin_drive == ($past(reg_wdata[6], 2) ? $past(reg_wdata[3:0], 2) : 4'h0))
        else $error("Awake pin drive wrong");
    sleep_route_a: assert property (cfg_wr ##1 (!cfg_wr && deepest_sleep_mode) |=>
        cal_pin_drive == {3'h0, $past(reg_wdata[7], 2) && $past(reg_wdata[6], 2)})
        else $error("Sleep pin drive wrong");
    level_gate_a: assert property ((cal_pin_level & ~cal_pin_drive) == 4'h0)
        else $error("Level on undriven pin");
    drive_hold_a: assert property ((!cfg_wr && $stable(deepest_sleep_mode)) [*2] |=>
        $stable(cal_pin_drive)) else $error("Drive moved without cause");
    cfg_readback_a: assert property (cfg_wr ##1 (reg_read && reg_addr == OFF_CAL) |=>
        reg_rdata == $past(reg_wdata, 2)) else $error("Config readback wrong");
    unmapped_read_a: assert property (reg_read && (reg_addr == 4'h0 || reg_addr > OFF_YEAR &&
        reg_addr < OFF_CAL) |=> reg_rdata == 8'h00) else $error("Unmapped read not zero");
    read_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("Read data outside read cycle");
    reset_quiet_a: assert property (disable iff (1'b0) reset |=>
        cal_pin_drive == 4'h0 && reg_rdata == 8'h00) else $error("Outputs active after reset");
    // Main scenarios
    cover property (cfg_wr && reg_wdata[6]);
    cover property (deepest_sleep_mode && cal_pin_drive.route_port0_pin5);
    cover property ($rose(cal_pin_level.route_port2_pin3));
endmodule
bind rtc_calendar_cal rtc_calendar_cal_chk chk (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .deepest_sleep_mode, .cal_pin_level, .cal_pin_drive);
`default_nettype wire

// File: rtc_calendar_cal_tb.sv
// Purpose: Self-checking bench for the calendar and calibration block.
// Assumes: Short tick and wave parameters set at the instance.
// Notes: Expected drive, calendar and half-period values come from the tables below.
`default_nettype none
module rtc_calendar_cal_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rtc_cal_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic deepest_sleep_mode = 1'b0;
    logic [7:0] reg_rdata;
    cal_pins_t cal_pin_level;
    cal_pins_t cal_pin_drive;
    int err_count = 0;
    int n_checks = 0;
    int n;
    logic [7:0] v, d, m, y;
    // Rows: sleep, config, expected drive
    logic [12:0] drv_tab [10] = '{13'h04FF, 13'h0411, 13'h0422, 13'h0444, 13'h0488,
        13'h00F0, 13'h1CF1, 13'h14F0, 13'h18F0, 13'h1C01};
    // Rows: month, date, year, then expected date, month, year
    logic [47:0] cal_tab [10] = '{48'h011F00_010200, 48'h041E00_010500, 48'h091E00_010A00,
        48'h021C01_010301, 48'h021C04_1D0204, 48'h021D60_010360, 48'h021C00_010300,
        48'h0C1F05_010106, 48'h0D1F00_010101, 48'h0B1D00_1E0B00};
    int half_tab [4] = '{20, 10, 12, HALF_16KHZ};

    rtc_calendar_cal #(.TICK_CYCLES_P(24'd250), .HALF_1HZ_P(24'd20), .HALF_512HZ_P(24'd10),
        .HALF_500HZ_P(24'd12)) DUT (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .deepest_sleep_mode(deepest_sleep_mode), .cal_pin_level(cal_pin_level),
        .cal_pin_drive(cal_pin_drive));

    // 10 MHz clock
    always #50 clk_sys = ~clk_sys;

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    // Strobe stays high for a following write; rd or the caller lowers it
    task automatic wr(input logic [3:0] a, input logic [7:0] dt);
        reg_addr <= a;
        reg_wdata <= dt;
        reg_write <= 1'b1;
        @(posedge clk_sys);
    endtask

    // Read data taken in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        reg_write <= 1'b0;
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(posedge clk_sys);
        q = reg_rdata;
    endtask

    // Length of the third level interval on the first pin
    task automatic half_len(output int k);
        logic p;
        repeat (3)
        begin
            p = cal_pin_level.route_port0_pin5;
            k = 0;
            while (cal_pin_level.route_port0_pin5 === p && k < 2000)
            begin
                @(posedge clk_sys);
                k++;
            end
        end
    endtask

    task automatic end_of_test;
        $display("Mismatches %0d, checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #5_000_000;
        err_count++;
        end_of_test();
    end

    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        for (int a = 0; a < 16; a++)
        begin
            rd(4'(a), v);
            chk({16'h0, v}, (a == 6 || a == 7) ? 24'h1 : 24'h0);
        end
        foreach (drv_tab[i])
        begin
            deepest_sleep_mode <= drv_tab[i][12];
            wr(OFF_CAL, drv_tab[i][11:4]);
            rd(OFF_CAL, v);
            chk({16'h0, v}, {16'h0, drv_tab[i][11:4]});
            chk({20'h0, cal_pin_drive}, {20'h0, drv_tab[i][3:0]});
        end
        deepest_sleep_mode <= 1'b0;
        wr(OFF_CAL, 8'h00);
        foreach (cal_tab[i])
        begin
            wr(OFF_DATE, cal_tab[i][39:32]);
            wr(OFF_MONTH, cal_tab[i][47:40]);
            wr(OFF_YEAR, cal_tab[i][31:24]);
            wr(OFF_HOUR, HOUR_MAX);
            wr(OFF_MIN, SEC_MAX);
            wr(OFF_SEC, SEC_MAX);
            wr(OFF_FRAC, FRAC_MAX);
            reg_write <= 1'b0;
            repeat (260) @(posedge clk_sys);
            rd(OFF_DATE, d);
            rd(OFF_MONTH, m);
            rd(OFF_YEAR, y);
            chk({d, m, y}, cal_tab[i][23:0]);
        end
        // Fast timebase carries into seconds within 260 cycles
        wr(OFF_CAL, 8'h20);
        wr(OFF_SEC, 8'h00);
        wr(OFF_FRAC, 8'h00);
        reg_write <= 1'b0;
        repeat (260) @(posedge clk_sys);
        rd(OFF_SEC, v);
        chk({16'h0, v}, 24'h1);
        for (int s = 0; s < 4; s++)
        begin
            wr(OFF_CAL, 8'h41 | 8'(s << 4));
            reg_write <= 1'b0;
            half_len(n);
            chk(24'(n), 24'(half_tab[s]));
        end
        // Reset in mid-run with the output active
        reset <= 1'b1;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk({20'h0, cal_pin_drive}, 24'h0);
        rd(OFF_CAL, v);
        chk({16'h0, v}, 24'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
